// [verilog/adcpp_cfg.svh]
// Constants for the converter parallel port, both ends
//
// Behaviour
// - Data pins are three-state, strobe controlled
// - 10-bit word and low-byte reads: two low pins zero
// - Word mode: pin 8 data, else upper-byte select
// - Byte mode, select low: low byte
// - Byte mode, select high: upper nibble low
// - Upper byte read carries channel id
// - Host writes upper byte bits 4-7 zero
// - 10-bit low byte: two zeros, six data
// - Busy rises after start fall, holds
// - Busy falls once result is stored
// - Track resumes on thirteenth master edge
// - Conversion: 13 master periods plus delay
// - Host clock continuous or burst
// - Start fall: hold and begin conversion
// - Start rise wakes from auto power-down
// - Write only with write and select low
// - Result driven after read fall, select low
// - Host pairs select with read or write
// - Pins 9-11 used only in word mode
// - Word select high full word, else bytes
`ifndef ADCPP_CFG_SVH
`define ADCPP_CFG_SVH
`define ADCPP_W           12
`define ADCPP_CLK_NS      50
`define ADCPP_CONV_EDGES  4'hD
`define ADCPP_TAIL_NS     50
`define ADCPP_TAIL_CYC    ((`ADCPP_TAIL_NS + `ADCPP_CLK_NS - 1) / `ADCPP_CLK_NS)
`define ADCPP_PM_MSB      1
`define ADCPP_PM_LSB      0
`define ADCPP_PM_SHUT     2'h1
`define ADCPP_PM_STBY     2'h2
`define ADCPP_ADDR_MSB    4
`define ADCPP_ADDR_LSB    2
`define ADCPP_SHDW_BIT    5
`define ADCPP_SEL_PIN     8
`define ADCPP_CTRL_RST    12'h000
`define ADCPP_OE_WORD     12'hFFF
`define ADCPP_OE_BYTE     12'h0FF
`define ADCPP_OE_SEL      12'h100
`define ADCPP_STROBE_CYC  8
`define ADCPP_GAP_CYC     4
`define ADCPP_START_LOW   2
`define ADCPP_CLKDIV      4
`endif

// [verilog/adcpp_pkg.sv]
// Types shared by both ends of the converter parallel port
package adcpp_pkg;
  typedef enum logic [1:0] {CV_IDLE, CV_CONV, CV_TAIL, CV_SLEEP} adcpp_cst_t;
  typedef enum logic [1:0] {HS_IDLE, HS_STRB, HS_GAP} adcpp_hst_t;
endpackage

// [verilog/adcpp_if.sv]
// Pins between the converter and its host
`timescale 1ns/1ns
interface adcpp_if;
  logic        cs_n;
  logic        rd_n;
  logic        wr_n;
  logic        word_sel;
  logic        conversion_start_n;
  logic        master_clock_in;
  logic        busy;
  logic [11:0] db_dev_o;
  logic [11:0] db_dev_oe;
  logic [11:0] db_host_o;
  logic [11:0] db_host_oe;
  logic [11:0] db;
  // Undriven bits settle low, as tied-off lines would
  assign db = (db_dev_o & db_dev_oe) | (db_host_o & db_host_oe);
  modport device (input cs_n, rd_n, wr_n, word_sel, conversion_start_n, master_clock_in, db,
                  output db_dev_o, db_dev_oe, busy);
  modport host (output cs_n, rd_n, wr_n, word_sel, conversion_start_n, master_clock_in,
                db_host_o, db_host_oe, input db, busy);
endinterface

// [verilog/adcpp_host.sv]
// Host end: drives strobes, start and master clock
`timescale 1ns/1ns
`include "adcpp_cfg.svh"
module adcpp_host #(
  parameter bit BURST = 1'b0
) (
  input  wire logic        clock,
  input  wire logic        rst,
  adcpp_if.host            pins,
  input  wire logic        start_conv,
  input  wire logic        word_mode,
  input  wire logic        acc_req,
  input  wire logic        acc_write,
  input  wire logic        acc_upper,
  input  wire logic [11:0] acc_wdata,
  output logic             acc_ready,
  output logic             acc_done,
  output logic [11:0]      acc_rdata,
  output logic             conv_done
);
  import adcpp_pkg::*;

  adcpp_hst_t  st_q, st_d;
  logic [3:0]  cnt_q, cnt_d;
  logic        wr_q, wr_d, up_q, up_d, ws_q, ws_d;
  logic [11:0] wd_q, wd_d, rd_q, rd_d, o_q, o_d, oe_q, oe_d;
  logic        cs_q, cs_d, rdn_q, rdn_d, wrn_q, wrn_d, dn_q, dn_d;
  logic        rdy_q, rdy_d;
  logic [12:0] s1_q, s2_q;
  logic        bp_q, cv_q, cv_d, cd_q, cd_d, run_q, run_d, mc_q, mc_d;
  logic [1:0]  sc_q, sc_d;
  logic [3:0]  dv_q, dv_d;

  ////////////////////////////////////////////////////////////////////////
  // Busy and bus come from the far end: two stages first
  always_ff @(posedge clock) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      bp_q <= 1'b0;
    end else begin
      s1_q <= {pins.busy, pins.db};
      s2_q <= s1_q;
      bp_q <= s2_q[12];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    up_d = up_q;
    ws_d = ws_q;
    wd_d = wd_q;
    rd_d = rd_q;
    o_d = '0;
    oe_d = '0;
    cs_d = 1'b1;
    rdn_d = 1'b1;
    wrn_d = 1'b1;
    dn_d = 1'b0;
    case (st_q)
      HS_IDLE: if (acc_req) begin
        st_d = HS_STRB;
        cnt_d = '0;
        wr_d = acc_write;
        up_d = acc_upper;
        ws_d = word_mode;
        wd_d = acc_wdata;
      end
      HS_STRB: begin
        cs_d = 1'b0;
        rdn_d = wr_q;
        wrn_d = ~wr_q;
        cnt_d = cnt_q + 4'h1;
        if (!ws_q) begin
          o_d[`ADCPP_SEL_PIN] = up_q;
          oe_d = `ADCPP_OE_SEL;
        end
        if (wr_q) begin
          if (ws_q) begin
            o_d = wd_q;
            oe_d = `ADCPP_OE_WORD;
          end else if (up_q) begin
            o_d[7:0] = {4'h0, wd_q[11:8]};
            oe_d = `ADCPP_OE_BYTE | `ADCPP_OE_SEL;
          end else begin
            o_d[7:0] = wd_q[7:0];
            oe_d = `ADCPP_OE_BYTE | `ADCPP_OE_SEL;
          end
        end
        if (cnt_q == 4'(`ADCPP_STROBE_CYC - 1)) begin
          st_d = HS_GAP;
          cnt_d = '0;
          cs_d = 1'b1;
          rdn_d = 1'b1;
          wrn_d = 1'b1;
          o_d = '0;
          oe_d = '0;
          if (!wr_q) rd_d = s2_q[11:0];
        end
      end
      HS_GAP: begin
        // Gap lets the far end release the bus before the next drive
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == 4'(`ADCPP_GAP_CYC - 1)) begin
          st_d = HS_IDLE;
          dn_d = 1'b1;
        end
      end
      default: st_d = HS_IDLE;
    endcase
    // Ready registered so the output comes from a flop
    rdy_d = (st_d == HS_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    sc_d = sc_q;
    cv_d = cv_q;
    cd_d = 1'b0;
    run_d = run_q;
    dv_d = dv_q;
    mc_d = mc_q;
    if (start_conv && sc_q == '0) begin
      sc_d = 2'(`ADCPP_START_LOW);
      cv_d = 1'b0;
      run_d = 1'b1;
    end else if (sc_q != '0) begin
      sc_d = sc_q - 2'h1;
      if (sc_q == 2'h1) cv_d = 1'b1;
    end
    if (bp_q && !s2_q[12]) begin
      cd_d = 1'b1;
      run_d = 1'b0;
    end
    if (!BURST || run_q) begin
      dv_d = dv_q + 4'h1;
      if (dv_q == 4'(`ADCPP_CLKDIV - 1)) begin
        dv_d = '0;
        mc_d = ~mc_q;
      end
    end else begin
      dv_d = '0;
      mc_d = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= HS_IDLE;
      cnt_q <= '0;
      wr_q <= 1'b0;
      up_q <= 1'b0;
      ws_q <= 1'b1;
      wd_q <= '0;
      rd_q <= '0;
      o_q <= '0;
      oe_q <= '0;
      cs_q <= 1'b1;
      rdn_q <= 1'b1;
      wrn_q <= 1'b1;
      dn_q <= 1'b0;
      rdy_q <= 1'b1;
      sc_q <= '0;
      cv_q <= 1'b1;
      cd_q <= 1'b0;
      run_q <= 1'b0;
      dv_q <= '0;
      mc_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      up_q <= up_d;
      ws_q <= ws_d;
      wd_q <= wd_d;
      rd_q <= rd_d;
      o_q <= o_d;
      oe_q <= oe_d;
      cs_q <= cs_d;
      rdn_q <= rdn_d;
      wrn_q <= wrn_d;
      dn_q <= dn_d;
      rdy_q <= rdy_d;
      sc_q <= sc_d;
      cv_q <= cv_d;
      cd_q <= cd_d;
      run_q <= run_d;
      dv_q <= dv_d;
      mc_q <= mc_d;
    end
  end

  assign pins.cs_n = cs_q;
  assign pins.rd_n = rdn_q;
  assign pins.wr_n = wrn_q;
  assign pins.word_sel = ws_q;
  assign pins.conversion_start_n = cv_q;
  assign pins.master_clock_in = mc_q;
  assign pins.db_host_o = o_q;
  assign pins.db_host_oe = oe_q;
  assign acc_ready = rdy_q;
  assign acc_done = dn_q;
  assign acc_rdata = rd_q;
  assign conv_done = cd_q;
endmodule

// [verilog/adcpp_device.sv]
// Converter end: conversion sequencing and parallel port
`timescale 1ns/1ns
`include "adcpp_cfg.svh"
module adcpp_device #(
  parameter int RES_BITS = 12
) (
  input  wire logic                clock,
  input  wire logic                rst,
  adcpp_if.device                  pins,
  input  wire logic [RES_BITS-1:0] conv_sample,
  output logic                     hold_mode,
  output logic                     powered_up,
  output logic [11:0]              ctrl_word,
  output logic [11:0]              shadow_word
);
  import adcpp_pkg::*;

  // Only the two documented resolutions fit the padding logic
  if (RES_BITS != 12 && RES_BITS != 10) begin
    $error("RES_BITS must be 12 or 10");
  end

  localparam int PAD = `ADCPP_W - RES_BITS;

  // Sample widened to the word, low pad bits zero
  function automatic logic [11:0] widen(input logic [RES_BITS-1:0] s);
    logic [11:0] w;
    w = 12'(s);
    return 12'(w << PAD);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin inputs: first stage feeds only the second
  logic [17:0] s1_q, s2_q;
  logic        cs_n, rd_n, wr_n, wsel, cv_n, mck;
  logic [11:0] dbi;

  always_ff @(posedge clock) begin
    if (rst) begin
      s1_q <= '1;
      s2_q <= '1;
    end else begin
      s1_q <= {pins.cs_n, pins.rd_n, pins.wr_n, pins.word_sel,
               pins.conversion_start_n, pins.master_clock_in, pins.db};
      s2_q <= s1_q;
    end
  end

  assign {cs_n, rd_n, wr_n, wsel, cv_n, mck, dbi} = s2_q;

  ////////////////////////////////////////////////////////////////////////
  // Conversion sequencing
  adcpp_cst_t  st_q, st_d;
  logic [3:0]  cnt_q, cnt_d;
  logic        busy_q, busy_d, hold_q, hold_d, up_q, up_d;
  logic        cvp_q, mkp_q;
  logic [11:0] smp_q, smp_d, res_q, res_d;
  logic [2:0]  sid_q, sid_d, id_q, id_d;
  logic [11:0] ctrl_q, ctrl_d, shd_q, shd_d;
  logic        cv_fall, cv_rise, mk_rise;

  assign cv_fall = cvp_q & ~cv_n;
  assign cv_rise = ~cvp_q & cv_n;
  assign mk_rise = ~mkp_q & mck;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    busy_d = busy_q;
    hold_d = hold_q;
    up_d = up_q;
    smp_d = smp_q;
    res_d = res_q;
    sid_d = sid_q;
    id_d = id_q;
    case (st_q)
      CV_IDLE: begin
        if (cv_fall) begin
          hold_d = 1'b1;
          smp_d = widen(conv_sample);
          sid_d = ctrl_q[`ADCPP_ADDR_MSB:`ADCPP_ADDR_LSB];
          busy_d = 1'b1;
          cnt_d = '0;
          st_d = CV_CONV;
        end
      end
      CV_CONV: begin
        if (mk_rise) begin
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == `ADCPP_CONV_EDGES - 4'h1) begin
            hold_d = 1'b0;
            cnt_d = '0;
            st_d = CV_TAIL;
          end
        end
      end
      CV_TAIL: begin
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == 4'(`ADCPP_TAIL_CYC - 1)) begin
          res_d = smp_q;
          id_d = sid_q;
          busy_d = 1'b0;
          cnt_d = '0;
          if (ctrl_q[`ADCPP_PM_MSB:`ADCPP_PM_LSB] == `ADCPP_PM_SHUT ||
              ctrl_q[`ADCPP_PM_MSB:`ADCPP_PM_LSB] == `ADCPP_PM_STBY) begin
            up_d = 1'b0;
            st_d = CV_SLEEP;
          end else begin
            st_d = CV_IDLE;
          end
        end
      end
      CV_SLEEP: begin
        if (cv_rise) begin
          up_d = 1'b1;
          st_d = CV_IDLE;
        end
      end
      default: st_d = CV_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes and result reads
  logic        wact, wact_q, ract, sh_q, sh_d;
  logic [11:0] wl_q, wl_d, tgt, wv, o_q, o_d, oe_q, oe_d;

  assign wact = ~cs_n & ~wr_n;
  assign ract = ~cs_n & ~rd_n;
  assign tgt = sh_q ? shd_q : ctrl_q;

  always_comb begin
    // Sample the bus only while writing
    wl_d = wact ? dbi : wl_q;
    if (wsel) begin
      wv = wl_q;
    end else if (wl_q[`ADCPP_SEL_PIN]) begin
      wv = {wl_q[3:0], tgt[7:0]};
    end else begin
      wv = {tgt[11:8], wl_q[7:0]};
    end
    ctrl_d = ctrl_q;
    shd_d = shd_q;
    sh_d = sh_q;
    // Commit on strobe end so the whole pulse's data is seen
    if (wact_q && !wact) begin
      if (sh_q) shd_d = wv;
      else ctrl_d = wv;
      // Shadow follows a word or upper-byte control write with its flag set
      if (wsel || wl_q[`ADCPP_SEL_PIN]) sh_d = !sh_q && wv[`ADCPP_SHDW_BIT];
    end
    o_d = '0;
    oe_d = '0;
    if (ract) begin
      if (wsel) begin
        o_d = res_q;
        oe_d = `ADCPP_OE_WORD;
      // Pin 8 is select input here
      end else if (dbi[`ADCPP_SEL_PIN]) begin
        o_d[7:0] = {1'b0, id_q, res_q[11:8]};
        oe_d = `ADCPP_OE_BYTE;
      end else begin
        o_d[7:0] = res_q[7:0];
        oe_d = `ADCPP_OE_BYTE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= CV_IDLE;
      cnt_q <= '0;
      busy_q <= 1'b0;
      hold_q <= 1'b0;
      up_q <= 1'b1;
      smp_q <= '0;
      res_q <= '0;
      sid_q <= '0;
      id_q <= '0;
      cvp_q <= 1'b1;
      mkp_q <= 1'b1;
      wl_q <= '0;
      wact_q <= 1'b0;
      sh_q <= 1'b0;
      ctrl_q <= `ADCPP_CTRL_RST;
      shd_q <= `ADCPP_CTRL_RST;
      o_q <= '0;
      oe_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      hold_q <= hold_d;
      up_q <= up_d;
      smp_q <= smp_d;
      res_q <= res_d;
      sid_q <= sid_d;
      id_q <= id_d;
      cvp_q <= cv_n;
      mkp_q <= mck;
      wl_q <= wl_d;
      wact_q <= wact;
      sh_q <= sh_d;
      ctrl_q <= ctrl_d;
      shd_q <= shd_d;
      o_q <= o_d;
      oe_q <= oe_d;
    end
  end

  assign pins.busy = busy_q;
  assign pins.db_dev_o = o_q;
  assign pins.db_dev_oe = oe_q;
  assign hold_mode = hold_q;
  assign powered_up = up_q;
  assign ctrl_word = ctrl_q;
  assign shadow_word = shd_q;
endmodule

// [tb/adcpp_properties.sv]
// Interface checker for the converter parallel port
`timescale 1ns/1ns
module adcpp_properties (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        cs_n,
  input wire logic        rd_n,
  input wire logic        wr_n,
  input wire logic        word_sel,
  input wire logic        conversion_start_n,
  input wire logic        master_clock_in,
  input wire logic        busy,
  input wire logic [11:0] db_dev_o,
  input wire logic [11:0] db_dev_oe,
  input wire logic [11:0] db_host_o,
  input wire logic [11:0] db_host_oe,
  input wire logic [11:0] db
);
  logic [4:0] rise_cnt_q;
  logic [4:0] rise_cnt_d;
  logic       mclk_q;
  logic       mclk_d;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////
  // Master clock rises while busy; a rise just before busy is seen late by the device, so 12 may show
  always_comb begin
    mclk_d     = master_clock_in;
    rise_cnt_d = rise_cnt_q;
    if (!busy) begin
      rise_cnt_d = 5'h00;
    end else if (master_clock_in && !mclk_q) begin
      rise_cnt_d = rise_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rise_cnt_q <= 5'h00;
      mclk_q     <= 1'b0;
    end else begin
      rise_cnt_q <= rise_cnt_d;
      mclk_q     <= mclk_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  a_busy_follows_start: assert property (
    $rose(busy) |-> !$past(conversion_start_n, 3) && $past(conversion_start_n, 4))
    else $error("busy rose without a start fall three cycles before");
  a_busy_clock_count: assert property (
    $fell(busy) |-> rise_cnt_q inside {5'h0C, 5'h0D}) else $error("busy fell after a wrong clock count");
  a_busy_bounded: assert property (
    $rose(busy) |-> ##[1:120] !busy) else $error("conversion did not end in time");
  a_bus_released: assert property (
    (cs_n || rd_n) [*4] |-> db_dev_oe == 12'h000) else $error("device drives bus outside a read");
  a_word_read_width: assert property (
    (!cs_n && !rd_n && word_sel) [*4] |-> db_dev_oe == 12'hFFF) else $error("word read not full width");
  a_byte_read_width: assert property (
    (!cs_n && !rd_n && !word_sel) [*4] |-> db_dev_oe == 12'h0FF) else $error("byte read width wrong");
  a_upper_top_zero: assert property (
    (!cs_n && !rd_n && !word_sel && db[8]) [*4] |-> db_dev_o[7] == 1'b0) else $error("upper byte bit 7 set");
  a_no_contention: assert property (
    (db_dev_oe & db_host_oe) == 12'h000) else $error("both ends drive one data pin");
  a_strobe_select: assert property (
    (!rd_n || !wr_n) |-> !cs_n && (rd_n || wr_n)) else $error("strobe without select or both strobes");
  a_strobe_timing: assert property (
    $fell(cs_n) |-> (!cs_n) [*7] ##1 cs_n [*4]) else $error("select width or gap wrong");
  a_upper_write_zero: assert property (
    !cs_n && !wr_n && !word_sel && db[8] |-> db[7:4] == 4'h0) else $error("upper byte write bits 7..4 set");
  a_start_pulse: assert property (
    $fell(conversion_start_n) |=> !conversion_start_n ##1 conversion_start_n) else $error("start pulse width wrong");
endmodule

// [tb/testbench.sv]
// Self-checking bench joining host and converter ends
`timescale 1ns/1ns
module testbench;
  logic        clock;
  logic        rst;
  logic        start_conv;
  logic        word_mode;
  logic        acc_req;
  logic        acc_write;
  logic        acc_upper;
  logic [11:0] acc_wdata;
  logic        acc_ready;
  logic        acc_done;
  logic [11:0] acc_rdata;
  logic        conv_done;
  logic [9:0]  conv_sample;
  logic        hold_mode;
  logic        powered_up;
  logic [11:0] ctrl_word;
  logic [11:0] shadow_word;
  logic [11:0] rd;
  logic        saw_busy;
  int          failures;
  int          checks;

  adcpp_if u_adcpp_if ();

  adcpp_host #(.BURST(1'b0)) u_adcpp_host (
    .clock(clock), .rst(rst), .pins(u_adcpp_if), .start_conv(start_conv), .word_mode(word_mode),
    .acc_req(acc_req), .acc_write(acc_write), .acc_upper(acc_upper), .acc_wdata(acc_wdata),
    .acc_ready(acc_ready), .acc_done(acc_done), .acc_rdata(acc_rdata), .conv_done(conv_done));

  // Ten-bit variant so the zeroed low pins are exercised
  adcpp_device #(.RES_BITS(10)) u_adcpp_device (
    .clock(clock), .rst(rst), .pins(u_adcpp_if), .conv_sample(conv_sample), .hold_mode(hold_mode),
    .powered_up(powered_up), .ctrl_word(ctrl_word), .shadow_word(shadow_word));

  adcpp_properties u_adcpp_properties (
    .clock(clock), .rst(rst), .cs_n(u_adcpp_if.cs_n), .rd_n(u_adcpp_if.rd_n), .wr_n(u_adcpp_if.wr_n),
    .word_sel(u_adcpp_if.word_sel), .conversion_start_n(u_adcpp_if.conversion_start_n),
    .master_clock_in(u_adcpp_if.master_clock_in), .busy(u_adcpp_if.busy), .db_dev_o(u_adcpp_if.db_dev_o),
    .db_dev_oe(u_adcpp_if.db_dev_oe), .db_host_o(u_adcpp_if.db_host_o),
    .db_host_oe(u_adcpp_if.db_host_oe), .db(u_adcpp_if.db));

  ////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic step();
    @(posedge clock);
    #2;
  endtask

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One host access; word mode and byte half are held for the whole access
  task automatic access(input logic w, input logic wm, input logic up, input logic [11:0] wd);
    int n;
    n = 0;
    while (acc_ready !== 1'b1 && n < 60) begin
      step();
      n++;
    end
    acc_write = w;
    word_mode = wm;
    acc_upper = up;
    acc_wdata = wd;
    acc_req   = 1'b1;
    step();
    acc_req = 1'b0;
    n = 0;
    while (acc_done !== 1'b1 && n < 60) begin
      step();
      n++;
    end
    check("access done", {11'h000, acc_done}, 12'h001);
    rd = acc_rdata;
  endtask

  task automatic convert(input logic [9:0] s);
    int n;
    conv_sample = s;
    start_conv  = 1'b1;
    step();
    start_conv = 1'b0;
    n = 0;
    while (u_adcpp_if.busy !== 1'b1 && n < 20) begin
      step();
      n++;
    end
    check("busy high", {11'h000, u_adcpp_if.busy}, 12'h001);
    check("hold at start", {11'h000, hold_mode}, 12'h001);
    n = 0;
    while (conv_done !== 1'b1 && n < 200) begin
      step();
      n++;
    end
    check("conv done", {11'h000, conv_done}, 12'h001);
    check("busy low", {11'h000, u_adcpp_if.busy}, 12'h000);
    check("track again", {11'h000, hold_mode}, 12'h000);
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (6000) @(posedge clock);
    failures = failures + 1;
    tally_and_finish();
  end

  initial begin
    rst         = 1'b1;
    start_conv  = 1'b0;
    word_mode   = 1'b1;
    acc_req     = 1'b0;
    acc_write   = 1'b0;
    acc_upper   = 1'b0;
    acc_wdata   = 12'h000;
    conv_sample = 10'h000;
    saw_busy    = 1'b0;
    failures    = 0;
    checks      = 0;
    repeat (16) @(posedge clock);
    #2;
    rst = 1'b0;
    repeat (4) step();
    check("powered reset", {11'h000, powered_up}, 12'h001);
    check("ctrl reset", ctrl_word, 12'h000);
    // Word writes: shadow-next flag steers the following word to the shadow register
    access(1'b1, 1'b1, 1'b0, 12'h020);
    check("ctrl word", ctrl_word, 12'h020);
    access(1'b1, 1'b1, 1'b0, 12'hABC);
    check("shadow word", shadow_word, 12'hABC);
    check("ctrl kept", ctrl_word, 12'h020);
    access(1'b1, 1'b1, 1'b0, 12'h81C);
    check("ctrl back", ctrl_word, 12'h81C);
    // Channel 7 result 10'h297 sits at bits 11..2
    convert(10'h297);
    access(1'b0, 1'b1, 1'b0, 12'h000);
    check("word read", rd, 12'hA5C);
    access(1'b0, 1'b0, 1'b0, 12'h000);
    check("low byte read", rd, 12'h05C);
    access(1'b0, 1'b0, 1'b1, 12'h000);
    check("upper byte read", rd, 12'h17A);
    // Byte writes: low half keeps bit 11, upper half fills 11..8; power mode becomes auto-shutdown
    access(1'b1, 1'b0, 1'b0, 12'h00D);
    check("ctrl low byte", ctrl_word, 12'h80D);
    access(1'b1, 1'b0, 1'b1, 12'h300);
    check("ctrl upper byte", ctrl_word, 12'h30D);
    convert(10'h0FF);
    check("asleep", {11'h000, powered_up}, 12'h000);
    // A start pulse while asleep only wakes the converter
    start_conv = 1'b1;
    step();
    start_conv = 1'b0;
    repeat (12) begin
      step();
      if (u_adcpp_if.busy === 1'b1) saw_busy = 1'b1;
    end
    check("no conversion", {11'h000, saw_busy}, 12'h000);
    check("awake", {11'h000, powered_up}, 12'h001);
    access(1'b0, 1'b0, 1'b1, 12'h000);
    check("upper id three", rd, 12'h133);
    access(1'b0, 1'b1, 1'b0, 12'h000);
    check("word read two", rd, 12'h3FC);
    tally_and_finish();
  end
endmodule
